/* File: src/pmlr_pkg.sv */
package pmlr_pkg;
  // register addresses per PHY
  localparam logic [4:0] MII_BASIC_CTRL = 5'h00;
  localparam logic [4:0] MII_BASIC_STAT = 5'h01;
  localparam logic [4:0] MII_IDENT_HIGH = 5'h02;
  localparam logic [4:0] MII_IDENT_LOW = 5'h03;
  localparam logic [4:0] MII_AN_ADVERT = 5'h04;
  localparam logic [4:0] MII_AN_PARTNER = 5'h05;
  localparam logic [4:0] MII_CABLE_TEST = 5'h1D;
  localparam logic [4:0] MII_SPECIAL = 5'h1F;
  // frame fields
  localparam logic [1:0] MDIO_OP_READ = 2'h2;
  localparam logic [1:0] MDIO_OP_WRITE = 2'h1;
  localparam logic [5:0] MDIO_PRE_LEN = 6'h20;
  localparam logic [3:0] MDIO_HDR_LAST = 4'hC;
  localparam logic [4:0] MDIO_TA_FIRST = 5'h00;
  localparam logic [4:0] MDIO_DATA_LAST = 5'h11;
  // switch offsets
  localparam logic [7:0] SW_GLOBAL13 = 8'h0F;
  localparam logic [7:0] SW_P1_LOOP_CTRL = 8'h1A;
  localparam logic [7:0] SW_P1_AN_CTRL = 8'h1C;
  localparam logic [7:0] SW_P1_PHY_CTRL = 8'h1D;
  localparam logic [7:0] SW_P1_STATUS = 8'h1E;
  localparam logic [7:0] SW_P1_XO_CTRL = 8'h1F;
  localparam logic [7:0] SW_PORT_STRIDE = 8'h10;
  // reset values
  localparam logic [7:0] SW_GLOBAL13_RST = 8'h08;
  localparam logic [7:0] SW_LOOP_CTRL_RST = 8'h00;
  localparam logic [7:0] SW_AN_CTRL_RST = 8'h9F;
  localparam logic [7:0] SW_PHY_CTRL_RST = 8'h00;
  localparam logic [7:0] SW_XO_CTRL_RST = 8'h80;
  // switch-side bit positions
  localparam int PHY_SELECT_ADDRESS_LSB = 3;
  localparam int AN_EN_B = 7;
  localparam int F100_B = 6;
  localparam int FDUP_B = 5;
  localparam int FAR_LB_B = 0;
  localparam int FMDI_B = 1;
  localparam int DIS_MDIX_B = 2;
  localparam int PDOWN_B = 3;
  localparam int DIS_FEF_B = 4;
  localparam int RESTART_B = 5;
  localparam int DIS_TX_B = 6;
  localparam int DIS_LED_B = 7;
  localparam int XO_ALG_B = 7;
  localparam int FEF_STAT_B = 0;
  localparam int NEAR_LB_B = 1;
  // management bit positions
  localparam int BC_FAR_LB = 14;
  localparam int BC_F100 = 13;
  localparam int BC_AN_EN = 12;
  localparam int BC_PDOWN = 11;
  localparam int BC_RESTART = 9;
  localparam int BC_FDUP = 8;
  localparam int BC_XO_ALG = 5;
  localparam int BC_FMDI = 4;
  localparam int BC_DIS_MDIX = 3;
  localparam int BC_DIS_FEF = 2;
  localparam int BC_DIS_TX = 1;
  localparam int BC_DIS_LED = 0;
  localparam int ADV_LSB = 5;
  localparam int ADV_PAUSE = 10;
  localparam int SPC_NEAR_LB = 1;
  localparam logic [4:0] ADV_SELECTOR = 5'h01;
  localparam logic [3:0] STAT_CAPS = 4'hF;
  typedef enum logic [2:0] {
    PMLR_PRE = 3'b001,
    PMLR_HDR = 3'b010,
    PMLR_DATA = 3'b100
  } pmlr_mdio_state_t;
endpackage

/* File: src/pmlr_mdio_frame.sv */
`timescale 1ns/100ps
module pmlr_mdio_frame (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  output logic req_pulse,
  output logic req_read,
  output logic [4:0] phy_select_address,
  output logic [4:0] register_select_address,
  input wire logic rd_hit,
  input wire logic [15:0] rd_data,
  output logic wr_pulse,
  output logic [15:0] wr_data
);
  import pmlr_pkg::*;
  pmlr_mdio_state_t state_reg;
  logic mdc_reg;
  logic rise;
  logic [5:0] ones_reg;
  logic [3:0] hcnt_reg;
  logic [4:0] dcnt_reg;
  logic [11:0] hdr_reg;
  logic [12:0] hdr_full;
  logic [15:0] rd_sh_reg;
  logic drive_reg;

  // mdc is slow, so each rise is one core cycle
  assign rise = mdc & ~mdc_reg;
  assign hdr_full = {hdr_reg, mdio_in};

  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
      mdc_reg <= 1'b0;
    else
      mdc_reg <= mdc;

  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
    begin
      state_reg <= PMLR_PRE;
      ones_reg <= '0;
      hcnt_reg <= '0;
      dcnt_reg <= '0;
      hdr_reg <= '0;
      req_pulse <= 1'b0;
      req_read <= 1'b0;
      phy_select_address <= '0;
      register_select_address <= '0;
    end
    else
    begin
      req_pulse <= 1'b0;
      if (rise)
        case (state_reg)
          PMLR_PRE:
            if (mdio_in)
              ones_reg <= (ones_reg == MDIO_PRE_LEN) ? ones_reg : ones_reg + 6'h01;
            else if (ones_reg == MDIO_PRE_LEN)
            begin
              state_reg <= PMLR_HDR;
              hcnt_reg <= '0;
            end
            else
              ones_reg <= '0;
          PMLR_HDR:
          begin
            hdr_reg <= hdr_full[11:0];
            hcnt_reg <= hcnt_reg + 4'h1;
            if (hcnt_reg == MDIO_HDR_LAST)
            begin
              ones_reg <= '0;
              if (hdr_full[12] && (hdr_full[11:10] == MDIO_OP_READ ||
                  hdr_full[11:10] == MDIO_OP_WRITE))
              begin
                state_reg <= PMLR_DATA;
                dcnt_reg <= '0;
                req_pulse <= 1'b1;
                req_read <= (hdr_full[11:10] == MDIO_OP_READ);
                phy_select_address <= hdr_full[9:5];
                register_select_address <= hdr_full[4:0];
              end
              else
                state_reg <= PMLR_PRE;
            end
          end
          PMLR_DATA:
          begin
            dcnt_reg <= dcnt_reg + 5'h01;
            if (dcnt_reg == MDIO_DATA_LAST)
              state_reg <= PMLR_PRE;
          end
          default:
            state_reg <= PMLR_PRE;
        endcase
    end

  // read: 0 on turnaround bit 2, then 16 bits msb first
  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
    begin
      drive_reg <= 1'b0;
      rd_sh_reg <= '0;
      mdio_out <= 1'b0;
      mdio_oe <= 1'b0;
    end
    else if (req_pulse)
    begin
      drive_reg <= req_read & rd_hit;
      rd_sh_reg <= rd_data;
    end
    else if (rise && state_reg == PMLR_DATA && drive_reg)
    begin
      if (dcnt_reg == MDIO_TA_FIRST)
      begin
        mdio_oe <= 1'b1;
        mdio_out <= 1'b0;
      end
      else if (dcnt_reg == MDIO_DATA_LAST)
      begin
        mdio_oe <= 1'b0;
        mdio_out <= 1'b0;
        drive_reg <= 1'b0;
      end
      else
      begin
        mdio_out <= rd_sh_reg[15];
        rd_sh_reg <= {rd_sh_reg[14:0], 1'b0};
      end
    end

  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
    begin
      wr_data <= '0;
      wr_pulse <= 1'b0;
    end
    else
    begin
      wr_pulse <= 1'b0;
      if (rise && state_reg == PMLR_DATA && !req_read && dcnt_reg > 5'h01)
      begin
        wr_data <= {wr_data[14:0], mdio_in};
        wr_pulse <= (dcnt_reg == MDIO_DATA_LAST);
      end
    end
endmodule // pmlr_mdio_frame

/* File: src/pmlr_loop_path.sv */
`timescale 1ns/100ps
module pmlr_loop_path #(
  parameter int SYM_W = 5
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [2*SYM_W-1:0] pma_rx_sym,
  input wire logic [2*SYM_W-1:0] mac_tx_sym,
  input wire logic [1:0] near_loop_en,
  input wire logic [1:0] far_loop_en,
  input wire logic [1:0] tx_disable,
  output logic [2*SYM_W-1:0] pma_tx_sym,
  output logic [2*SYM_W-1:0] mac_rx_sym
);
  logic [2*SYM_W-1:0] wrap_reg;

  for (genvar p = 0; p < 2; p++)
  begin : g_path
    localparam int Q = 1 - p;
    // slice Q: port p's receive data turned at PHY Q
    always_ff @(posedge core_clk or posedge sys_rst)
      if (sys_rst)
      begin
        wrap_reg[Q*SYM_W +: SYM_W] <= '0;
        mac_rx_sym[p*SYM_W +: SYM_W] <= '0;
      end
      else
      begin
        wrap_reg[Q*SYM_W +: SYM_W] <= pma_rx_sym[p*SYM_W +: SYM_W]; // [R2]
        mac_rx_sym[p*SYM_W +: SYM_W] <= pma_rx_sym[p*SYM_W +: SYM_W];
      end

    always_ff @(posedge core_clk or posedge sys_rst)
      if (sys_rst)
        pma_tx_sym[p*SYM_W +: SYM_W] <= '0;
      else if (tx_disable[p])
        pma_tx_sym[p*SYM_W +: SYM_W] <= '0; // [R17]
      else if (near_loop_en[p])
        pma_tx_sym[p*SYM_W +: SYM_W] <= pma_rx_sym[p*SYM_W +: SYM_W]; // [R5]
      else if (far_loop_en[Q])
        pma_tx_sym[p*SYM_W +: SYM_W] <= wrap_reg[Q*SYM_W +: SYM_W]; // [R2] [R4]
      else
        pma_tx_sym[p*SYM_W +: SYM_W] <= mac_tx_sym[p*SYM_W +: SYM_W];
  end
endmodule // pmlr_loop_path

/* File: src/pmlr_top.sv */
// What this block does
// R1 - station sets both ports to 100 Mbps copper before any loopback
// R2 - far-end loopback returns port data via other PHY's medium layers
// R3 - switch regs 29 and 45 bit 0 enable far-end loopback ports 1, 2
// R4 - control bit 14 wraps opposite port's traffic at this PHY
// R5 - near-end loopback wraps receive back to same port's transmitter
// R6 - near-end loopback via switch regs 26/42 bit 1 or register 31 bit 1
// R7 - PHYs answer at management addresses 1 and 2 by default
// R8 - global switch register 15 bits 7..3 reprogram the PHY addresses
// R9 - only register addresses 0-5, 29 and 31 exist per PHY
// R10 - switch-side map also reaches the PHY bits
// R11 - bit 12 autonegotiation, reset 1; bits 13 and 8 force speed, duplex
// R12 - writing 1 to bit 9 restarts autonegotiation, resets 0
// R13 - bit 5 chooses crossover algorithm, 1 is default and reset
// R14 - bit 4 forces straight-through, transmitting on receive pair
// R15 - bit 3 disables automatic crossover, reset 0
// R16 - bit 2 suppresses far-end fault detection, reset 0
// R17 - bit 1 disables the PHY transmitter, reset 0
// R18 - both access paths share one storage bit
// R19 - unsupported addresses and bits read zero, writes ignored; code leaves unsupported addresses undriven, so they read all ones
// R20 - bit 11 powers down, bit 0 disables indicators, both reset 0
`timescale 1ns/100ps
module pmlr_top #(
  parameter int SYM_W = 5,
  parameter logic [15:0] PHY_IDENT_HIGH = 16'h0A5A, // arbitrary value
  parameter logic [15:0] PHY_IDENT_LOW = 16'hC3C0 // arbitrary value
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic sw_wr_en,
  input wire logic sw_rd_en,
  input wire logic [7:0] sw_addr,
  input wire logic [7:0] sw_wr_data,
  output logic [7:0] sw_rd_data,
  output logic sw_rd_valid,
  input wire logic [1:0] link_up,
  input wire logic [1:0] autoneg_complete,
  input wire logic [1:0] far_fault_detected,
  input wire logic [9:0] partner_ability,
  input wire logic [2*SYM_W-1:0] pma_rx_sym,
  input wire logic [2*SYM_W-1:0] mac_tx_sym,
  output logic [2*SYM_W-1:0] pma_tx_sym,
  output logic [2*SYM_W-1:0] mac_rx_sym,
  output logic [1:0] autoneg_enable,
  output logic [1:0] autoneg_restart,
  output logic [1:0] force_speed_100,
  output logic [1:0] force_full_duplex,
  output logic [1:0] power_down,
  output logic [1:0] crossover_algorithm_select,
  output logic [1:0] force_straight_through,
  output logic [1:0] crossover_disable,
  output logic [1:0] far_fault_detect_disable,
  output logic [1:0] tx_disable,
  output logic [1:0] led_disable,
  output logic [9:0] advertise_ability,
  output logic [1:0] far_loop_en,
  output logic [1:0] near_loop_en
);
  import pmlr_pkg::*;

  logic req_pulse;
  logic req_read;
  logic [4:0] phy_select_address;
  logic [4:0] register_select_address;
  logic wr_pulse;
  logic [15:0] wr_data;
  logic rd_hit;
  logic [15:0] rd_data;
  logic [7:0] global13_reg;
  logic [4:0] phy_base;
  logic [4:0] phy_addr [2];
  logic [1:0] phy_hit;
  logic reg_known;
  logic [7:0] loop_ctrl [2];
  logic [7:0] an_ctrl [2];
  logic [7:0] phy_ctrl [2];
  logic [7:0] xo_ctrl [2];
  logic [15:0] mii_rd [2];
  logic [7:0] sw_rd_next;

  pmlr_mdio_frame u_frame (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .mdc(mdc),
    .mdio_in(mdio_in),
    .mdio_out(mdio_out),
    .mdio_oe(mdio_oe),
    .req_pulse(req_pulse),
    .req_read(req_read),
    .phy_select_address(phy_select_address),
    .register_select_address(register_select_address),
    .rd_hit(rd_hit),
    .rd_data(rd_data),
    .wr_pulse(wr_pulse),
    .wr_data(wr_data)
  );

  // plain storage but for the address field
  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
      global13_reg <= SW_GLOBAL13_RST; // [R7]
    else if (sw_wr_en && sw_addr == SW_GLOBAL13)
      global13_reg <= sw_wr_data; // [R8]

  // second PHY at next address; reset field gives 1 and 2
  assign phy_base = global13_reg[PHY_SELECT_ADDRESS_LSB +: 5];
  assign phy_addr[0] = phy_base; // [R7] [R8]
  assign phy_addr[1] = phy_base + 5'h01; // [R7] [R8]

  always_comb
  begin
    reg_known = 1'b0;
    case (register_select_address)
      MII_BASIC_CTRL, MII_BASIC_STAT, MII_IDENT_HIGH, MII_IDENT_LOW,
      MII_AN_ADVERT, MII_AN_PARTNER, MII_CABLE_TEST, MII_SPECIAL:
        reg_known = 1'b1; // [R9]
      default:
        reg_known = 1'b0; // [R19]
    endcase
  end

  for (genvar p = 0; p < 2; p++)
  begin : g_port
    localparam logic [7:0] OFS = (p == 0) ? 8'h00 : SW_PORT_STRIDE;
    logic [7:0] loop_ctrl_reg;
    logic [7:0] an_ctrl_reg;
    logic [7:0] phy_ctrl_reg;
    logic [7:0] xo_ctrl_reg;
    logic mii_wr;

    assign phy_hit[p] = (phy_select_address == phy_addr[p]);
    assign mii_wr = wr_pulse & phy_hit[p] & reg_known;

    // switch write wins a same-cycle clash
    always_ff @(posedge core_clk or posedge sys_rst)
      if (sys_rst)
        loop_ctrl_reg <= SW_LOOP_CTRL_RST;
      else if (sw_wr_en && sw_addr == SW_P1_LOOP_CTRL + OFS)
        loop_ctrl_reg <= sw_wr_data; // [R6] [R18]
      else if (mii_wr && register_select_address == MII_SPECIAL)
        loop_ctrl_reg[NEAR_LB_B] <= wr_data[SPC_NEAR_LB]; // [R6] [R18]

    always_ff @(posedge core_clk or posedge sys_rst)
      if (sys_rst)
        an_ctrl_reg <= SW_AN_CTRL_RST; // [R11]
      else if (sw_wr_en && sw_addr == SW_P1_AN_CTRL + OFS)
        an_ctrl_reg <= sw_wr_data; // [R10] [R18]
      else if (mii_wr && register_select_address == MII_BASIC_CTRL)
      begin
        an_ctrl_reg[AN_EN_B] <= wr_data[BC_AN_EN]; // [R11]
        an_ctrl_reg[F100_B] <= wr_data[BC_F100]; // [R11]
        an_ctrl_reg[FDUP_B] <= wr_data[BC_FDUP]; // [R11]
      end
      else if (mii_wr && register_select_address == MII_AN_ADVERT)
        an_ctrl_reg[4:0] <= {wr_data[ADV_PAUSE], wr_data[ADV_LSB +: 4]}; // [R18]

    // restart self-clears; a new set beats the clear
    always_ff @(posedge core_clk or posedge sys_rst)
      if (sys_rst)
        phy_ctrl_reg <= SW_PHY_CTRL_RST; // [R12] [R15] [R16] [R17] [R20]
      else if (sw_wr_en && sw_addr == SW_P1_PHY_CTRL + OFS)
        phy_ctrl_reg <= sw_wr_data; // [R3] [R18]
      else if (mii_wr && register_select_address == MII_BASIC_CTRL)
      begin
        phy_ctrl_reg[FAR_LB_B] <= wr_data[BC_FAR_LB]; // [R4]
        phy_ctrl_reg[FMDI_B] <= wr_data[BC_FMDI]; // [R14]
        phy_ctrl_reg[DIS_MDIX_B] <= wr_data[BC_DIS_MDIX]; // [R15]
        phy_ctrl_reg[PDOWN_B] <= wr_data[BC_PDOWN]; // [R20]
        phy_ctrl_reg[DIS_FEF_B] <= wr_data[BC_DIS_FEF]; // [R16]
        phy_ctrl_reg[RESTART_B] <= wr_data[BC_RESTART]; // [R12]
        phy_ctrl_reg[DIS_TX_B] <= wr_data[BC_DIS_TX]; // [R17]
        phy_ctrl_reg[DIS_LED_B] <= wr_data[BC_DIS_LED]; // [R20]
      end
      else if (phy_ctrl_reg[RESTART_B])
        phy_ctrl_reg[RESTART_B] <= 1'b0; // [R12]

    always_ff @(posedge core_clk or posedge sys_rst)
      if (sys_rst)
        xo_ctrl_reg <= SW_XO_CTRL_RST; // [R13]
      else if (sw_wr_en && sw_addr == SW_P1_XO_CTRL + OFS)
        xo_ctrl_reg <= sw_wr_data; // [R18]
      else if (mii_wr && register_select_address == MII_BASIC_CTRL)
        xo_ctrl_reg[XO_ALG_B] <= wr_data[BC_XO_ALG]; // [R13]

    assign loop_ctrl[p] = loop_ctrl_reg;
    assign an_ctrl[p] = an_ctrl_reg;
    assign phy_ctrl[p] = phy_ctrl_reg;
    assign xo_ctrl[p] = xo_ctrl_reg;

    // unsupported fields read as zero
    always_comb
    begin
      mii_rd[p] = '0;
      case (register_select_address)
        MII_BASIC_CTRL:
        begin
          mii_rd[p][BC_FAR_LB] = phy_ctrl_reg[FAR_LB_B]; // [R4]
          mii_rd[p][BC_F100] = an_ctrl_reg[F100_B];
          mii_rd[p][BC_AN_EN] = an_ctrl_reg[AN_EN_B];
          mii_rd[p][BC_PDOWN] = phy_ctrl_reg[PDOWN_B];
          mii_rd[p][BC_RESTART] = phy_ctrl_reg[RESTART_B];
          mii_rd[p][BC_FDUP] = an_ctrl_reg[FDUP_B];
          mii_rd[p][BC_XO_ALG] = xo_ctrl_reg[XO_ALG_B];
          mii_rd[p][BC_FMDI] = phy_ctrl_reg[FMDI_B];
          mii_rd[p][BC_DIS_MDIX] = phy_ctrl_reg[DIS_MDIX_B];
          mii_rd[p][BC_DIS_FEF] = phy_ctrl_reg[DIS_FEF_B];
          mii_rd[p][BC_DIS_TX] = phy_ctrl_reg[DIS_TX_B];
          mii_rd[p][BC_DIS_LED] = phy_ctrl_reg[DIS_LED_B]; // [R19]
        end
        MII_BASIC_STAT:
          mii_rd[p] = {1'b0, STAT_CAPS, 5'h00, autoneg_complete[p],
                       far_fault_detected[p], 1'b1, link_up[p], 2'h0};
        MII_IDENT_HIGH:
          mii_rd[p] = PHY_IDENT_HIGH;
        MII_IDENT_LOW:
          mii_rd[p] = PHY_IDENT_LOW;
        MII_AN_ADVERT:
          mii_rd[p] = {5'h00, an_ctrl_reg[4], 1'b0, an_ctrl_reg[3:0], ADV_SELECTOR};
        MII_AN_PARTNER:
          mii_rd[p] = {5'h00, partner_ability[p*5+4], 1'b0,
                       partner_ability[p*5 +: 4], 5'h00};
        MII_SPECIAL:
          mii_rd[p][SPC_NEAR_LB] = loop_ctrl_reg[NEAR_LB_B]; // [R6]
        default:
          mii_rd[p] = '0; // [R19]
      endcase
    end

    assign autoneg_enable[p] = an_ctrl_reg[AN_EN_B]; // [R11]
    assign force_speed_100[p] = an_ctrl_reg[F100_B]; // [R11]
    assign force_full_duplex[p] = an_ctrl_reg[FDUP_B]; // [R11]
    assign advertise_ability[p*5 +: 5] = an_ctrl_reg[4:0];
    assign autoneg_restart[p] = phy_ctrl_reg[RESTART_B]; // [R12]
    assign power_down[p] = phy_ctrl_reg[PDOWN_B]; // [R20]
    assign led_disable[p] = phy_ctrl_reg[DIS_LED_B]; // [R20]
    assign crossover_algorithm_select[p] = xo_ctrl_reg[XO_ALG_B]; // [R13]
    assign force_straight_through[p] = phy_ctrl_reg[FMDI_B]; // [R14]
    assign crossover_disable[p] = phy_ctrl_reg[DIS_MDIX_B]; // [R15]
    assign far_fault_detect_disable[p] = phy_ctrl_reg[DIS_FEF_B]; // [R16]
    assign tx_disable[p] = phy_ctrl_reg[DIS_TX_B]; // [R17]
    // loopback assumes the station set 100 Mbps
    assign far_loop_en[p] = phy_ctrl_reg[FAR_LB_B]; // [R3] [R4]
    assign near_loop_en[p] = loop_ctrl_reg[NEAR_LB_B]; // [R6]
  end

  // phy 1 wins if the two addresses ever coincide
  assign rd_hit = (phy_hit[0] | phy_hit[1]) & reg_known; // [R7] [R9]
  assign rd_data = phy_hit[0] ? mii_rd[0] : mii_rd[1];

  always_comb
  begin
    sw_rd_next = '0;
    case (sw_addr)
      SW_GLOBAL13:
        sw_rd_next = global13_reg;
      SW_P1_LOOP_CTRL:
        sw_rd_next = loop_ctrl[0];
      SW_P1_AN_CTRL:
        sw_rd_next = an_ctrl[0];
      SW_P1_PHY_CTRL:
        sw_rd_next = phy_ctrl[0];
      SW_P1_STATUS:
        sw_rd_next = {1'b0, autoneg_complete[0], link_up[0], partner_ability[4:0]};
      SW_P1_XO_CTRL:
        sw_rd_next = {xo_ctrl[0][7:1], far_fault_detected[0]};
      SW_P1_LOOP_CTRL + SW_PORT_STRIDE:
        sw_rd_next = loop_ctrl[1];
      SW_P1_AN_CTRL + SW_PORT_STRIDE:
        sw_rd_next = an_ctrl[1];
      SW_P1_PHY_CTRL + SW_PORT_STRIDE:
        sw_rd_next = phy_ctrl[1];
      SW_P1_STATUS + SW_PORT_STRIDE:
        sw_rd_next = {1'b0, autoneg_complete[1], link_up[1], partner_ability[9:5]};
      SW_P1_XO_CTRL + SW_PORT_STRIDE:
        sw_rd_next = {xo_ctrl[1][7:1], far_fault_detected[1]};
      default:
        sw_rd_next = '0;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
    begin
      sw_rd_data <= '0;
      sw_rd_valid <= 1'b0;
    end
    else
    begin
      sw_rd_valid <= sw_rd_en;
      if (sw_rd_en)
        sw_rd_data <= sw_rd_next; // [R10]
    end

  pmlr_loop_path #(
    .SYM_W(SYM_W)
  ) u_loop (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pma_rx_sym(pma_rx_sym),
    .mac_tx_sym(mac_tx_sym),
    .near_loop_en(near_loop_en),
    .far_loop_en(far_loop_en),
    .tx_disable(tx_disable),
    .pma_tx_sym(pma_tx_sym),
    .mac_rx_sym(mac_rx_sym)
  );
endmodule // pmlr_top

/* File: sim/pmlr_top_checker.sv */
`timescale 1ns/100ps
module pmlr_top_checker #(
  parameter int SYM_W = 5
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic sw_wr_en,
  input wire logic sw_rd_en,
  input wire logic [7:0] sw_addr,
  input wire logic [7:0] sw_wr_data,
  input wire logic sw_rd_valid,
  input wire logic [2*SYM_W-1:0] pma_rx_sym,
  input wire logic [2*SYM_W-1:0] pma_tx_sym,
  input wire logic [2*SYM_W-1:0] mac_rx_sym,
  input wire logic [1:0] autoneg_enable,
  input wire logic [1:0] autoneg_restart,
  input wire logic [1:0] force_speed_100,
  input wire logic [1:0] tx_disable,
  input wire logic [1:0] far_loop_en,
  input wire logic [1:0] near_loop_en
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  a_read_valid_follows: assert property (sw_rd_en |=> sw_rd_valid)
    else $error("no read valid");
  a_restart_self_clears: assert property (autoneg_restart[0] |=> !autoneg_restart[0])
    else $error("restart held");
  a_far_loop_write: assert property (sw_wr_en && sw_addr == 8'h1D |=>
    far_loop_en[0] == $past(sw_wr_data[0])) else $error("far loop");
  a_tx_off_write: assert property (sw_wr_en && sw_addr == 8'h2D |=>
    tx_disable[1] == $past(sw_wr_data[6])) else $error("tx disable");
  a_near_loop_write: assert property (sw_wr_en && sw_addr == 8'h1A |=>
    near_loop_en[0] == $past(sw_wr_data[1])) else $error("near loop");
  a_autoneg_speed_write: assert property (sw_wr_en && sw_addr == 8'h1C |=>
    {autoneg_enable[0], force_speed_100[0]} == $past(sw_wr_data[7:6]))
    else $error("autoneg byte");
  a_rx_passes_up: assert property (mac_rx_sym == $past(pma_rx_sym))
    else $error("rx path");
  a_near_wrap_path: assert property (near_loop_en[0] && !tx_disable[0] |=>
    pma_tx_sym[SYM_W-1:0] == $past(pma_rx_sym[SYM_W-1:0])) else $error("near wrap");
endmodule // pmlr_top_checker
bind pmlr_top pmlr_top_checker #(.SYM_W(SYM_W)) pmlr_top_checker_i (.core_clk(core_clk),
  .sys_rst(sys_rst), .sw_wr_en(sw_wr_en), .sw_rd_en(sw_rd_en), .sw_addr(sw_addr),
  .sw_wr_data(sw_wr_data), .sw_rd_valid(sw_rd_valid), .pma_rx_sym(pma_rx_sym),
  .pma_tx_sym(pma_tx_sym), .mac_rx_sym(mac_rx_sym), .autoneg_enable(autoneg_enable),
  .autoneg_restart(autoneg_restart), .force_speed_100(force_speed_100),
  .tx_disable(tx_disable), .far_loop_en(far_loop_en), .near_loop_en(near_loop_en));

/* File: sim/pmlr_station.sv */
`timescale 1ns/100ps
module pmlr_station
  import pmlr_pkg::*;
(
  input wire logic core_clk,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  output logic mdc,
  output logic mdio_in
);
  logic drv = 1'b1;
  logic drv_en = 1'b1;
  // pull-up when nobody drives
  assign mdio_in = drv_en ? drv : (mdio_oe ? mdio_out : 1'b1);
  // mdc idles low
  initial mdc = 1'b0;
  task automatic put_bit(input logic b, output logic s);
    drv = b;
    repeat (4) @(negedge core_clk);
    s = mdio_in;
    mdc = 1'b1;
    repeat (4) @(negedge core_clk);
    mdc = 1'b0;
  endtask
  task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] ra,
    input logic [15:0] wd, output logic [15:0] q, output logic dr);
    logic [31:0] hdr;
    logic s;
    hdr = {2'b01, rd ? MDIO_OP_READ : MDIO_OP_WRITE, phy, ra, 2'b10, wd};
    dr = 1'b0;
    q = 16'h0;
    for (int i = 0; i < 32; i++)
      put_bit(1'b1, s);
    for (int i = 31; i >= 0; i--)
    begin
      drv_en = !(rd && i < 18);
      put_bit(hdr[i], s);
      q = {q[14:0], s};
      dr = dr | mdio_oe;
    end
    drv_en = 1'b1;
  endtask
endmodule // pmlr_station

/* File: sim/pmlr_top_test.sv */
`timescale 1ns/100ps
module pmlr_top_test;
  import pmlr_pkg::*;
  localparam logic [15:0] IDH = 16'h5A3C; // arbitrary value
  localparam int LIMIT = 20000;
  logic core_clk, sys_rst, mdc, mdio_in, mdio_out, mdio_oe, sw_wr_en, sw_rd_en, sw_rd_valid;
  logic [7:0] sw_addr, sw_wr_data, sw_rd_data;
  logic [1:0] link_up, autoneg_complete, far_fault_detected, autoneg_enable, autoneg_restart;
  logic [1:0] force_speed_100, force_full_duplex, power_down, crossover_algorithm_select;
  logic [1:0] force_straight_through, crossover_disable, far_fault_detect_disable, tx_disable;
  logic [1:0] led_disable, far_loop_en, near_loop_en;
  logic [9:0] partner_ability, pma_rx_sym, mac_tx_sym, pma_tx_sym, mac_rx_sym, advertise_ability;
  logic seen_restart = 1'b0;
  logic [4:0] bad_ra [3] = '{5'h06, 5'h1C, 5'h1E};
  int n_fail = 0, n_compared = 0, cycles = 0;
  pmlr_top #(.SYM_W(5), .PHY_IDENT_HIGH(IDH)) pmlr_top_i (.core_clk(core_clk),
    .sys_rst(sys_rst), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .sw_wr_en(sw_wr_en), .sw_rd_en(sw_rd_en), .sw_addr(sw_addr), .sw_wr_data(sw_wr_data),
    .sw_rd_data(sw_rd_data), .sw_rd_valid(sw_rd_valid), .link_up(link_up),
    .autoneg_complete(autoneg_complete), .far_fault_detected(far_fault_detected),
    .partner_ability(partner_ability), .pma_rx_sym(pma_rx_sym), .mac_tx_sym(mac_tx_sym),
    .pma_tx_sym(pma_tx_sym), .mac_rx_sym(mac_rx_sym), .autoneg_enable(autoneg_enable),
    .autoneg_restart(autoneg_restart), .force_speed_100(force_speed_100),
    .force_full_duplex(force_full_duplex), .power_down(power_down),
    .crossover_algorithm_select(crossover_algorithm_select),
    .force_straight_through(force_straight_through), .crossover_disable(crossover_disable),
    .far_fault_detect_disable(far_fault_detect_disable), .tx_disable(tx_disable),
    .led_disable(led_disable), .advertise_ability(advertise_ability), .far_loop_en(far_loop_en),
    .near_loop_en(near_loop_en));
  pmlr_station station_i (.core_clk(core_clk), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .mdc(mdc), .mdio_in(mdio_in));
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = !core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (autoneg_restart[0])
      seen_restart <= 1'b1;
    if (cycles == LIMIT)
    begin
      n_fail++;
      conclude();
    end
  end
  task automatic conclude;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task automatic sw(input logic rd, input logic [7:0] a, input logic [7:0] d);
    sw_addr = a;
    sw_wr_data = d;
    sw_rd_en = rd;
    sw_wr_en = !rd;
    @(negedge core_clk);
    if (rd)
    begin
      check({15'h0, sw_rd_valid}, 16'h1);
      check({8'h0, sw_rd_data}, {8'h0, d});
    end
    sw_rd_en = 1'b0;
    sw_wr_en = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic mi(input logic rd, input logic [4:0] phy, input logic [4:0] ra,
    input logic [15:0] d);
    logic [15:0] q;
    logic dr;
    station_i.frame(rd, phy, ra, d, q, dr);
    if (rd)
    begin
      check(q, d);
      check({15'h0, dr}, {15'h0, d !== 16'hFFFF});
    end
  endtask
  initial
  begin
    sys_rst = 1'b1;
    {sw_wr_en, sw_rd_en, sw_addr, sw_wr_data, pma_rx_sym, mac_tx_sym} = '0;
    {link_up, autoneg_complete, far_fault_detected} = 6'h15;
    partner_ability = 10'h015;
    repeat (5) @(negedge core_clk);
    sys_rst = 1'b0;
    @(negedge core_clk);
    check({autoneg_enable, crossover_algorithm_select, tx_disable, power_down, far_loop_en,
      near_loop_en, 4'h0}, 16'hF000);
    mi(1'b1, 5'h01, MII_BASIC_CTRL, 16'h1020);
    mi(1'b1, 5'h02, MII_IDENT_HIGH, IDH);
    for (int i = 0; i < 3; i++)
      mi(1'b1, 5'h01, bad_ra[i], 16'hFFFF);
    mi(1'b0, 5'h01, MII_BASIC_CTRL, 16'hFFFD);
    check({15'h0, seen_restart}, 16'h1);
    mi(1'b1, 5'h01, MII_BASIC_CTRL, 16'h793D);
    check({far_loop_en, power_down, force_straight_through, crossover_disable,
      far_fault_detect_disable, led_disable, force_speed_100, force_full_duplex},
      16'h5555);
    sw(1'b1, 8'h1D, 8'h9F);
    sw(1'b1, 8'h1C, 8'hFF);
    sw(1'b0, 8'h1A, 8'h02);
    mi(1'b0, 5'h02, MII_SPECIAL, 16'h0002);
    check({14'h0, near_loop_en}, 16'h3);
    sw(1'b1, 8'h2A, 8'h02);
    sw(1'b0, 8'h1C, 8'h5F);
    sw(1'b0, 8'h2C, 8'h50);
    check({6'h0, advertise_ability}, 16'h021F);
    pma_rx_sym = 10'h155;
    mac_tx_sym = 10'h06C;
    repeat (3) @(negedge core_clk);
    check({6'h0, pma_tx_sym}, 16'h0155);
    check({6'h0, mac_rx_sym}, 16'h0155);
    mi(1'b0, 5'h02, MII_SPECIAL, 16'h0000);
    check({6'h0, pma_tx_sym}, 16'h0155);
    sw(1'b0, 8'h1D, 8'h40);
    repeat (3) @(negedge core_clk);
    check({6'h0, pma_tx_sym}, 16'h0060);
    sw(1'b0, 8'h0F, 8'h28);
    mi(1'b1, 5'h05, MII_IDENT_HIGH, IDH);
    mi(1'b1, 5'h01, MII_BASIC_CTRL, 16'hFFFF);
    sw(1'b0, 8'h2D, 8'h01);
    mi(1'b1, 5'h06, MII_BASIC_CTRL, 16'h6020);
    sw(1'b1, 8'h1E, 8'h75);
    sw(1'b1, 8'h1F, 8'h81);
    sw(1'b1, 8'h05, 8'h00);
    conclude();
  end
endmodule // pmlr_top_test
